// ==== rtl/cell_port_pkg.sv ====
// Package: register map, reset values and carrier types of the cell port register group
package cell_port_pkg;
  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_SUM = 6'h00;
  localparam logic [5:0] IDX_ENSUM = 6'h01;
  localparam logic [5:0] IDX_CELL_VALIDATION_CONTROL = 6'h0c;
  localparam logic [5:0] IDX_CB1 = 6'h0d;
  localparam logic [5:0] IDX_CB2 = 6'h0e;
  localparam logic [5:0] IDX_UDF2 = 6'h0f;
  localparam logic [5:0] IDX_IMSK2 = 6'h25;
  localparam logic [5:0] IDX_IMSK3 = 6'h26;
  localparam logic [5:0] IDX_IMSK4 = 6'h27;
  localparam logic [5:0] IDX_ENCT = 6'h28;
  localparam logic [5:0] IDX_TXCI = 6'h2c;
  localparam logic [5:0] IDX_GATE = 6'h30;
  // ==========================================================
  // Field positions
  localparam int TXCLR_BIT = 7;
  localparam int RXCLR_BIT = 6;
  localparam int PSENSE_BIT = 2;
  localparam int ODIS_BIT = 5;
  localparam int DISCARD_BIT = 6;
  localparam int PLCP_BIT = 4;
  localparam int TXSUM_BIT = 1;
  localparam int RXSUM_BIT = 0;
  localparam int PARERR_BIT = 7;
  // ==========================================================
  // Reset values and writable masks
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ENCT = 8'hfc;
  localparam logic [7:0] MASK_ENSUM = 8'h13;
  localparam logic [7:0] MASK_CB1 = 8'h07;
  localparam logic [7:0] MASK_CB2 = 8'h3f;
  localparam logic [7:0] MASK_ENCT = 8'hfc;
  localparam logic [7:0] MASK_CELL_VALIDATION_CONTROL = 8'h40;
  localparam logic [7:0] MASK_GATE = 8'h07;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [31:0] IDLE_HDR_RST = 32'h00000001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic link_clk;
    logic tx_enb_n;
    logic tx_par;
    logic [7:0] tx_data;
    logic [4:0] tx_addr;
    logic [4:0] rx_addr;
  } pin_t;
  // Pin levels of an idle, unaddressed bus
  localparam pin_t PIN_IDLE = '{link_clk: 1'b0, tx_enb_n: 1'b1, tx_par: 1'b0, tx_data: 8'h00,
                                tx_addr: 5'h1f, rx_addr: 5'h1f};
  typedef struct packed {
    logic valid;
    logic [31:0] header;
  } hdr_t;
endpackage

// ==== rtl/cell_port_utopia_ctrl_irq_regs.sv ====
// Per-port cell bus control, idle screening and summary interrupt register group
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Three idle mask bytes, reset zero, read/write
// - Set mask bit ignores header bit
// - Idle cells dropped only when discard set
// - Writing bit 7 clears transmit pointers
// - Writing bit 6 clears receive pointers
// - Parity sense: 1 even, 0 odd
// - Fill threshold sets cell-available point
// - Output disable silences the cell-available drive enable and both selects
// - Respond only to own port address
// - Address resets to port number
// - User octet two sent in wide mode
// - Indications latch only when enabled
// - Summary bit 4 carries framer interrupt
// - Summary bits track cell indication registers
// - Summary enable selects pin contributors
// - Pin needs port, delineator, pin gates
// - Transmit enables, bits 7..2, reset fc
// - Enabled transmit events reach delineator flag
// - Event on rising status edge when enabled
// - Reading indication register clears it
module cell_port_utopia_ctrl_irq_regs #(
  parameter logic [3:0] PORT_NUM = 4'h0,
  parameter logic [31:0] IDLE_HEADER = cell_port_pkg::IDLE_HDR_RST
) (
  input wire logic REF_CLK_I, // 100 MHz clock
  input wire logic RESETN_I, // Synchronous reset, low
  input wire logic CE_I, // Clock enable
  input wire logic [7:0] S_AXI_AWADDR_I, // Write address
  input wire logic S_AXI_AWVALID_I, // Write address valid
  output logic S_AXI_AWREADY_O, // Write address ready
  input wire logic [31:0] S_AXI_WDATA_I, // Write data
  input wire logic [3:0] S_AXI_WSTRB_I, // Write strobes
  input wire logic S_AXI_WVALID_I, // Write data valid
  output logic S_AXI_WREADY_O, // Write data ready
  output logic [1:0] S_AXI_BRESP_O, // Write response
  output logic S_AXI_BVALID_O, // Write response valid
  input wire logic S_AXI_BREADY_I, // Write response ready
  input wire logic [7:0] S_AXI_ARADDR_I, // Read address
  input wire logic S_AXI_ARVALID_I, // Read address valid
  output logic S_AXI_ARREADY_O, // Read address ready
  output logic [31:0] S_AXI_RDATA_O, // Read data
  output logic [1:0] S_AXI_RRESP_O, // Read response
  output logic S_AXI_RVALID_O, // Read valid
  input wire logic S_AXI_RREADY_I, // Read ready
  input wire cell_port_pkg::pin_t PINS_I, // Cell bus pins, asynchronous
  input wire cell_port_pkg::hdr_t RX_HDR_I, // Received header
  input wire logic [2:0] TX_FREE_CELLS_I, // Free transmit cell slots
  input wire logic [7:2] TX_STATUS_I, // Transmit status levels
  input wire logic RX_CELL_IRQ_I, // Receive indication pending
  input wire logic PLCP_IRQ_I, // Framer interrupt, high
  input wire logic WIDE_MODE_I, // 16-bit bus mode
  output logic TX_FIFO_CLEAR_O, // Transmit pointer clear pulse
  output logic RX_FIFO_CLEAR_O, // Receive pointer clear pulse
  output logic CELL_IDLE_O, // Header matched idle pattern
  output logic CELL_DROP_O, // Drop this cell
  output logic TX_CLAV_O, // Transmit cell available
  output logic TX_CLAV_OE_O, // Cell available drive enable
  output logic TX_SELECT_O, // Transmit port selected
  output logic RX_SELECT_O, // Receive port selected
  output logic [7:0] RX_UDF2_O, // User octet two value
  output logic RX_UDF2_PAR_O, // Parity of user octet two
  output logic CELL_IRQ_FLAG_O, // Delineator flag
  output logic INTERRUPT_OUT_N_O // Interrupt pin, low
);
  // ==========================================================
  // Helpers
  function automatic logic par_bit(input logic [7:0] d, input logic even);
    return even ? ^d : ~^d;
  endfunction
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wr, input logic [7:0] msk);
    return (old & ~msk) | (wr & msk);
  endfunction
  function automatic logic mapped(input logic [5:0] idx);
    case (idx)
      cell_port_pkg::IDX_SUM, cell_port_pkg::IDX_ENSUM, cell_port_pkg::IDX_CELL_VALIDATION_CONTROL,
      cell_port_pkg::IDX_CB1, cell_port_pkg::IDX_CB2, cell_port_pkg::IDX_UDF2,
      cell_port_pkg::IDX_IMSK2, cell_port_pkg::IDX_IMSK3, cell_port_pkg::IDX_IMSK4,
      cell_port_pkg::IDX_ENCT, cell_port_pkg::IDX_TXCI, cell_port_pkg::IDX_GATE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  default clocking cb @(posedge REF_CLK_I); endclocking
  // ==========================================================
  // Register bus slave
  logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [5:0] aw_idx_q;
  logic [7:0] wbyte_q;
  logic wstrb0_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic aw_full_d, w_full_d, bvalid_d, wr_go, wr_en, rd_go;
  logic [5:0] rd_idx;
  logic [7:0] rd_byte;
  assign wr_go = aw_full_q & w_full_q & ~bvalid_q;
  assign wr_en = wr_go & wstrb0_q;
  assign rd_go = S_AXI_ARVALID_I & arready_q;
  assign rd_idx = S_AXI_ARADDR_I[7:2];
  assign aw_full_d = (aw_full_q & ~wr_go) | (S_AXI_AWVALID_I & awready_q);
  assign w_full_d = (w_full_q & ~wr_go) | (S_AXI_WVALID_I & wready_q);
  assign bvalid_d = (bvalid_q & ~S_AXI_BREADY_I) | wr_go;
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= cell_port_pkg::RESP_OKAY;
      aw_idx_q <= 6'h00;
      wbyte_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (CE_I) begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      // One write at a time: both channels reopen once the response is taken
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q <= ~w_full_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
      if (S_AXI_AWVALID_I && awready_q) begin
        aw_idx_q <= S_AXI_AWADDR_I[7:2];
      end
      if (S_AXI_WVALID_I && wready_q) begin
        wbyte_q <= S_AXI_WDATA_I[7:0];
        wstrb0_q <= S_AXI_WSTRB_I[0];
      end
      if (wr_go) begin
        bresp_q <= mapped(aw_idx_q) ? cell_port_pkg::RESP_OKAY : cell_port_pkg::RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= cell_port_pkg::RESP_OKAY;
    end else if (CE_I) begin
      if (rd_go) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= {24'h000000, rd_byte};
        rresp_q <= mapped(rd_idx) ? cell_port_pkg::RESP_OKAY : cell_port_pkg::RESP_SLVERR;
      end else if (rvalid_q && S_AXI_RREADY_I) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end else if (!rvalid_q) begin
        arready_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Control registers
  logic [7:0] ensum_q, cell_validation_control_q, cb1_q, cb2_q, udf2_q, msk2_q, msk3_q, msk4_q, enct_q, gate_q;
  logic tx_clr_q, rx_clr_q;

  // Masked merge keeps unused bits zero; port-number resets
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      ensum_q <= cell_port_pkg::RST_ZERO;
      cell_validation_control_q <= cell_port_pkg::RST_ZERO;
      cb1_q <= cell_port_pkg::RST_ZERO;
      cb2_q <= {3'h0, 1'b0, PORT_NUM};
      udf2_q <= {4'h0, PORT_NUM};
      msk2_q <= cell_port_pkg::RST_ZERO;
      msk3_q <= cell_port_pkg::RST_ZERO;
      msk4_q <= cell_port_pkg::RST_ZERO;
      enct_q <= cell_port_pkg::RST_ENCT;
      gate_q <= cell_port_pkg::RST_ZERO;
    end else if (CE_I && wr_en) begin
      case (aw_idx_q)
        cell_port_pkg::IDX_ENSUM: ensum_q <= merge(ensum_q, wbyte_q, cell_port_pkg::MASK_ENSUM);
        cell_port_pkg::IDX_CELL_VALIDATION_CONTROL: cell_validation_control_q <= merge(cell_validation_control_q, wbyte_q, cell_port_pkg::MASK_CELL_VALIDATION_CONTROL);
        cell_port_pkg::IDX_CB1: cb1_q <= merge(cb1_q, wbyte_q, cell_port_pkg::MASK_CB1);
        cell_port_pkg::IDX_CB2: cb2_q <= merge(cb2_q, wbyte_q, cell_port_pkg::MASK_CB2);
        cell_port_pkg::IDX_UDF2: udf2_q <= wbyte_q;
        cell_port_pkg::IDX_IMSK2: msk2_q <= wbyte_q;
        cell_port_pkg::IDX_IMSK3: msk3_q <= wbyte_q;
        cell_port_pkg::IDX_IMSK4: msk4_q <= wbyte_q;
        cell_port_pkg::IDX_ENCT: enct_q <= merge(enct_q, wbyte_q, cell_port_pkg::MASK_ENCT);
        cell_port_pkg::IDX_GATE: gate_q <= merge(gate_q, wbyte_q, cell_port_pkg::MASK_GATE);
        default: ;
      endcase
    end
  end

  // Pointer clears are pulses; the bits never store
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      tx_clr_q <= 1'b0;
      rx_clr_q <= 1'b0;
    end else if (CE_I) begin
      tx_clr_q <= wr_en && aw_idx_q == cell_port_pkg::IDX_CB1 && wbyte_q[cell_port_pkg::TXCLR_BIT];
      rx_clr_q <= wr_en && aw_idx_q == cell_port_pkg::IDX_CB1 && wbyte_q[cell_port_pkg::RXCLR_BIT];
    end
  end

  // ==========================================================
  // Cell bus pins: two-stage sync, then edge detect on the link clock
  cell_port_pkg::pin_t pin1_q, pin2_q;
  logic link_prev_q, link_rise, tx_match, rx_match, tx_sel_q, rx_sel_q, par_err_q, odis;

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      pin1_q <= cell_port_pkg::PIN_IDLE;
      pin2_q <= cell_port_pkg::PIN_IDLE;
      link_prev_q <= 1'b0;
    end else if (CE_I) begin
      pin1_q <= PINS_I;
      pin2_q <= pin1_q;
      link_prev_q <= pin2_q.link_clk;
    end
  end

  assign link_rise = pin2_q.link_clk & ~link_prev_q;
  assign odis = cb2_q[cell_port_pkg::ODIS_BIT];
  // Only the own port address selects this port
  assign tx_match = pin2_q.tx_addr == cb2_q[4:0];
  assign rx_match = pin2_q.rx_addr == cb2_q[4:0];

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      tx_sel_q <= 1'b0;
      rx_sel_q <= 1'b0;
      par_err_q <= 1'b0;
    end else if (CE_I) begin
      par_err_q <= 1'b0;
      // Disabled port drops its selects at once
      tx_sel_q <= (link_rise ? tx_match : tx_sel_q) & ~odis;
      rx_sel_q <= (link_rise ? rx_match : rx_sel_q) & ~odis;
      if (link_rise) begin
        // Check transmit parity with selected sense
        par_err_q <= tx_sel_q && !pin2_q.tx_enb_n &&
          (par_bit(pin2_q.tx_data, cb1_q[cell_port_pkg::PSENSE_BIT]) != pin2_q.tx_par);
      end
    end
  end

  // ==========================================================
  // Idle screening and transmit fill level
  logic idle_hit;
  // Mask bits remove header bits from the compare
  assign idle_hit = ((RX_HDR_I.header ^ IDLE_HEADER) & ~{8'h00, msk2_q, msk3_q, msk4_q}) == 32'h00000000;
  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      CELL_IDLE_O <= 1'b0;
      CELL_DROP_O <= 1'b0;
      TX_CLAV_O <= 1'b0;
      TX_CLAV_OE_O <= 1'b0;
      RX_UDF2_O <= 8'h00;
      RX_UDF2_PAR_O <= 1'b0;
    end else if (CE_I) begin
      CELL_IDLE_O <= RX_HDR_I.valid & idle_hit;
      // Discard only with the discard control set
      CELL_DROP_O <= RX_HDR_I.valid & idle_hit & cell_validation_control_q[cell_port_pkg::DISCARD_BIT];
      // Available while more free slots than the threshold code
      TX_CLAV_O <= TX_FREE_CELLS_I > {1'b0, cb1_q[1:0]};
      TX_CLAV_OE_O <= tx_match & ~odis;
      // User octet two only in wide mode, with generated parity
      RX_UDF2_O <= WIDE_MODE_I ? udf2_q : 8'h00;
      RX_UDF2_PAR_O <= par_bit(WIDE_MODE_I ? udf2_q : 8'h00, cb1_q[cell_port_pkg::PSENSE_BIT]);
    end
  end

  // ==========================================================
  // Transmit cell indications and summary
  logic [7:2] stat_prev_q, txci_q, tx_set;
  logic [7:0] sum_q;
  logic txci_rd, irq_any, irq_n_q, flag_q;

  // Rising edges of status, gated by enables
  assign tx_set = ((TX_STATUS_I & ~stat_prev_q) | {par_err_q, 5'h00}) & enct_q[7:2];
  // Read of the indication register clears it
  assign txci_rd = rd_go && rd_idx == cell_port_pkg::IDX_TXCI;

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      stat_prev_q <= 6'h00;
      txci_q <= 6'h00;
    end else if (CE_I) begin
      stat_prev_q <= TX_STATUS_I;
      // Set wins over a clear in the same cycle so no event is lost
      txci_q <= (txci_q & ~{6{txci_rd}}) | tx_set;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      sum_q <= 8'h00;
    end else if (CE_I) begin
      sum_q <= {3'h0, PLCP_IRQ_I & ensum_q[cell_port_pkg::PLCP_BIT], 2'h0, |txci_q,
                RX_CELL_IRQ_I & ensum_q[cell_port_pkg::RXSUM_BIT]};
    end
  end

  // Summary enable selects, three gates for the pin
  assign irq_any = |(sum_q & ensum_q);

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      irq_n_q <= 1'b1;
      flag_q <= 1'b0;
    end else if (CE_I) begin
      irq_n_q <= ~(irq_any & (&gate_q[2:0]));
      // Enabled transmit events show on the delineator flag
      flag_q <= sum_q[cell_port_pkg::TXSUM_BIT] & ensum_q[cell_port_pkg::TXSUM_BIT];
    end
  end

  always_comb begin
    case (rd_idx)
      cell_port_pkg::IDX_SUM: rd_byte = sum_q;
      cell_port_pkg::IDX_ENSUM: rd_byte = ensum_q;
      cell_port_pkg::IDX_CELL_VALIDATION_CONTROL: rd_byte = cell_validation_control_q;
      cell_port_pkg::IDX_CB1: rd_byte = cb1_q;
      cell_port_pkg::IDX_CB2: rd_byte = cb2_q;
      cell_port_pkg::IDX_UDF2: rd_byte = udf2_q;
      cell_port_pkg::IDX_IMSK2: rd_byte = msk2_q;
      cell_port_pkg::IDX_IMSK3: rd_byte = msk3_q;
      cell_port_pkg::IDX_IMSK4: rd_byte = msk4_q;
      cell_port_pkg::IDX_ENCT: rd_byte = enct_q;
      cell_port_pkg::IDX_TXCI: rd_byte = {txci_q, 2'h0};
      cell_port_pkg::IDX_GATE: rd_byte = gate_q;
      default: rd_byte = 8'h00;
    endcase
  end
  assign S_AXI_AWREADY_O = awready_q;
  assign S_AXI_WREADY_O = wready_q;
  assign S_AXI_BVALID_O = bvalid_q;
  assign S_AXI_BRESP_O = bresp_q;
  assign S_AXI_ARREADY_O = arready_q;
  assign S_AXI_RVALID_O = rvalid_q;
  assign S_AXI_RDATA_O = rdata_q;
  assign S_AXI_RRESP_O = rresp_q;
  assign TX_FIFO_CLEAR_O = tx_clr_q;
  assign RX_FIFO_CLEAR_O = rx_clr_q;
  assign TX_SELECT_O = tx_sel_q;
  assign RX_SELECT_O = rx_sel_q;
  assign CELL_IRQ_FLAG_O = flag_q;
  assign INTERRUPT_OUT_N_O = irq_n_q;
  // ==========================================================
  // Checks
  mask_reset_a: assert property (!RESETN_I |=> msk2_q == 8'h00 && msk3_q == 8'h00 && msk4_q == 8'h00)
    else $error("idle masks not cleared by reset");
  idle_mask_a: assert property (disable iff (!RESETN_I) CE_I && RX_HDR_I.valid && idle_hit
    && cell_validation_control_q[6] |=> CELL_DROP_O && CELL_IDLE_O)
    else $error("masked idle header not dropped");
  idle_keep_a: assert property (disable iff (!RESETN_I) CE_I && !cell_validation_control_q[6] |=> !CELL_DROP_O)
    else $error("cell dropped with discard off");
  tx_clear_a: assert property (disable iff (!RESETN_I) TX_FIFO_CLEAR_O |-> $past(wr_en)
    && $past(aw_idx_q) == cell_port_pkg::IDX_CB1 && $past(wbyte_q[7]))
    else $error("transmit clear without write");
  rx_clear_a: assert property (disable iff (!RESETN_I) CE_I && wr_en && aw_idx_q == cell_port_pkg::IDX_CB1
    && wbyte_q[6] |=> RX_FIFO_CLEAR_O ##1 (!RX_FIFO_CLEAR_O || !$past(CE_I) || $past(wr_en)))
    else $error("receive clear pulse wrong");
  udf2_par_a: assert property (disable iff (!RESETN_I) CE_I && WIDE_MODE_I |=> RX_UDF2_O == $past(udf2_q)
    && (^{RX_UDF2_O, RX_UDF2_PAR_O}) == !$past(cb1_q[2]))
    else $error("user octet or parity wrong");
  clav_thr_a: assert property (disable iff (!RESETN_I) CE_I |=> TX_CLAV_O
    == ($past(TX_FREE_CELLS_I) > {1'b0, $past(cb1_q[1:0])}))
    else $error("cell available threshold wrong");
  out_dis_a: assert property (disable iff (!RESETN_I) CE_I && cb2_q[5] ##1 CE_I && cb2_q[5]
    |=> !TX_CLAV_OE_O && !TX_SELECT_O && !RX_SELECT_O)
    else $error("disabled port drives bus");
  addr_match_a: assert property (disable iff (!RESETN_I) TX_CLAV_OE_O |-> $past(pin2_q.tx_addr)
    == $past(cb2_q[4:0]))
    else $error("foreign address answered");
  phy_reset_a: assert property (!RESETN_I |=> cb2_q == {4'h0, PORT_NUM} && udf2_q == {4'h0, PORT_NUM})
    else $error("port address reset wrong");
  latch_en_a: assert property (disable iff (!RESETN_I) CE_I && !enct_q[3] && !txci_q[3] |=> !txci_q[3])
    else $error("indication latched while disabled");
  plcp_sum_a: assert property (disable iff (!RESETN_I) CE_I |=> sum_q[4]
    == ($past(PLCP_IRQ_I) && $past(ensum_q[4])))
    else $error("framer summary bit wrong");
  read_clr_a: assert property (disable iff (!RESETN_I) CE_I && txci_rd && tx_set == 6'h00
    |=> txci_q == 6'h00)
    else $error("read did not clear indications");
  rise_set_a: assert property (disable iff (!RESETN_I) CE_I && TX_STATUS_I[5] && !stat_prev_q[5]
    && enct_q[5] |=> txci_q[5])
    else $error("rising status not latched");
  irq_pin_a: assert property (disable iff (!RESETN_I) !INTERRUPT_OUT_N_O |-> $past(gate_q[2:0]) == 3'h7
    && $past(irq_any))
    else $error("interrupt pin without gates");
endmodule
`default_nettype wire

// ==== verification/atm_layer_model.sv ====
// ATM layer side model that drives the cell bus pins of one port
`timescale 1ns/100ps
`default_nettype none
module atm_layer_model (
  output var cell_port_pkg::pin_t PINS_O // Cell bus pins toward the port
);
  initial begin
    PINS_O = '0;
    PINS_O.tx_enb_n = 1'b1;
    PINS_O.tx_addr = 5'h1f;
    PINS_O.rx_addr = 5'h1f;
  end
  // ==========================================================
  // Link clock
  // Stands still between frames, so the port only sees edges inside a frame
  task automatic tick();
    #80 PINS_O.link_clk = 1'b1;
    #80 PINS_O.link_clk = 1'b0;
  endtask
  task automatic point(input logic [4:0] a);
    PINS_O.tx_addr = a;
    PINS_O.rx_addr = a;
  endtask
  // ==========================================================
  // Frame: address poll, one octet, then release
  // Released data shows the inverse so a stale value never looks valid
  task automatic frame(input logic [4:0] a, input logic [7:0] d, input logic par);
    point(a);
    tick();
    PINS_O.tx_enb_n = 1'b0;
    PINS_O.tx_data = d;
    PINS_O.tx_par = par;
    tick();
    PINS_O.tx_enb_n = 1'b1;
    PINS_O.tx_data = ~d;
    PINS_O.tx_par = ~par;
    point(5'h1f);
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench of the cell port register group
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [3:0] PORT = 4'h3;
  logic clk, rst_n, awv, wv, bready, arv, rready, wide, plcp, rxirq, ce;
  logic [7:0] awaddr, araddr, udf2;
  logic [31:0] wdata, rdata, rd_v;
  logic [1:0] bresp, rresp, rd_r, wr_b;
  logic [2:0] free;
  logic [7:2] txst;
  logic awr, wr_r, bv, arr, rv, clr_t, clr_r, idle, drop, clav, oe, tsel, rsel, upar, flag, irq_n;
  cell_port_pkg::hdr_t hdr;
  wire cell_port_pkg::pin_t pins;
  int bad_count, tests_run, cyc, n_tclr, n_rclr;
  logic [5:0] ix [9] = '{6'h01, 6'h0c, 6'h0d, 6'h0e, 6'h0f, 6'h25, 6'h26, 6'h27, 6'h28};
  logic [7:0] ex [9] = '{8'h00, 8'h00, 8'h00, {4'h0, PORT}, {4'h0, PORT}, 8'h00, 8'h00, 8'h00, 8'hfc};
  logic [7:0] mk [9] = '{8'h13, 8'h40, 8'h07, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hfc};

  cell_port_utopia_ctrl_irq_regs #(.PORT_NUM(PORT)) i_cell_port_utopia_ctrl_irq_regs (
    .REF_CLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr_r), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rready), .PINS_I(pins), .RX_HDR_I(hdr),
    .TX_FREE_CELLS_I(free), .TX_STATUS_I(txst), .RX_CELL_IRQ_I(rxirq), .PLCP_IRQ_I(plcp),
    .WIDE_MODE_I(wide), .TX_FIFO_CLEAR_O(clr_t), .RX_FIFO_CLEAR_O(clr_r), .CELL_IDLE_O(idle),
    .CELL_DROP_O(drop), .TX_CLAV_O(clav), .TX_CLAV_OE_O(oe), .TX_SELECT_O(tsel), .RX_SELECT_O(rsel),
    .RX_UDF2_O(udf2), .RX_UDF2_PAR_O(upar), .CELL_IRQ_FLAG_O(flag), .INTERRUPT_OUT_N_O(irq_n));
  atm_layer_model i_atm_layer_model (.PINS_O(pins));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Pulse counters and hang guard
  always @(posedge clk) begin
    cyc++;
    if (clr_t === 1'b1) n_tclr++;
    if (clr_r === 1'b1) n_rclr++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end
  // ==========================================================
  // Shared helpers
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Readies are sampled mid-cycle; they are registered, so that equals the next edge
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic a, w, b;
    @(posedge clk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      a = awr;
      w = wr_r;
      b = bv;
      wr_b = bresp;
      @(posedge clk);
      if (a) awv <= 1'b0;
      if (w) wv <= 1'b0;
    end while (!b);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] i);
    logic a, v;
    @(posedge clk);
    araddr <= {i, 2'b00};
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      a = arr;
      v = rv;
      rd_v = rdata;
      rd_r = rresp;
      @(posedge clk);
      if (a) arv <= 1'b0;
    end while (!v);
    rready <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [5:0] i, input logic [7:0] e);
    rd(i);
    chk(nm, rd_v, {24'h0, e});
  endtask
  task automatic hsend(input logic [31:0] h, input logic e_idle, input logic e_drop);
    @(posedge clk);
    hdr <= {1'b1, h};
    @(posedge clk);
    hdr.valid <= 1'b0;
    @(negedge clk);
    chk("idle flag", idle, e_idle);
    chk("drop flag", drop, e_drop);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    int t0, r0;
    foreach (ix[k]) rchk("reset value", ix[k], ex[k]);
    rd(6'h3f);
    chk("unmapped response", {30'h0, rd_r}, {30'h0, cell_port_pkg::RESP_SLVERR});
    wr(6'h3f, 8'hff);
    chk("unmapped write response", {30'h0, wr_b}, {30'h0, cell_port_pkg::RESP_SLVERR});
    t0 = n_tclr;
    r0 = n_rclr;
    foreach (ix[k]) wr(ix[k], 8'hff);
    foreach (ix[k]) rchk("written value", ix[k], mk[k]);
    chk("tx clear pulses", n_tclr - t0, 1);
    chk("rx clear pulses", n_rclr - r0, 1);
    wr(6'h00, 8'hff);
    chk("read-only write response", {30'h0, wr_b}, {30'h0, cell_port_pkg::RESP_OKAY});
    rchk("read-only summary", 6'h00, 8'h00);
    foreach (ix[k]) wr(ix[k], ex[k]);
    $display("register test done");
  endtask
  task automatic t_clav();
    // settings move only while the link is idle
    for (int c = 0; c < 4; c++) begin
      wr(6'h0d, {6'h0, c[1:0]});
      for (int f = 0; f < 5; f++) begin
        free <= f[2:0];
        cycles(3);
        chk("cell available", clav, f > c);
      end
    end
    ce <= 1'b0;
    free <= 3'h0;
    cycles(3);
    chk("frozen cell available", clav, 1'b1);
    ce <= 1'b1;
    wide <= 1'b1;
    wr(6'h0f, 8'h5b);
    for (int p = 0; p < 2; p++) begin
      wr(6'h0d, {5'h0, p[0], 2'b00});
      cycles(3);
      chk("user octet", udf2, 8'h5b);
      chk("user octet parity", upar, p[0] ? ^8'h5b : ~^8'h5b);
    end
    $display("cell available and parity test done");
  endtask
  task automatic t_idle();
    logic [31:0] h;
    h = cell_port_pkg::IDLE_HDR_RST;
    hsend(h ^ 32'h00010000, 1'b0, 1'b0);
    wr(6'h25, 8'h01);
    hsend(h ^ 32'h00010000, 1'b1, 1'b0);
    wr(6'h0c, 8'h40);
    hsend(h ^ 32'h00010000, 1'b1, 1'b1);
    hsend(h ^ 32'h00000180, 1'b0, 1'b0);
    wr(6'h26, 8'h01);
    wr(6'h27, 8'h80);
    hsend(h ^ 32'h00000180, 1'b1, 1'b1);
    $display("idle screening test done");
  endtask
  task automatic t_sel();
    i_atm_layer_model.point({1'b0, PORT});
    cycles(8);
    chk("drive enable matched", oe, 1'b1);
    i_atm_layer_model.point(5'h05);
    cycles(8);
    chk("drive enable other", oe, 1'b0);
    i_atm_layer_model.point({1'b0, PORT});
    wr(6'h0e, {3'b001, 1'b0, PORT});
    cycles(8);
    chk("drive enable disabled", oe, 1'b0);
    wr(6'h0e, {4'h0, PORT});
    $display("address test done");
  endtask
  task automatic t_irq();
    wr(6'h0d, 8'h04);
    wr(6'h30, 8'h07);
    wr(6'h01, 8'h02);
    i_atm_layer_model.frame({1'b0, PORT}, 8'h3c, 1'b1);
    cycles(12);
    chk("delineator flag", flag, 1'b1);
    chk("interrupt pin", irq_n, 1'b0);
    chk("transmit select", tsel, 1'b1);
    chk("receive select", rsel, 1'b1);
    rchk("summary tx", 6'h00, 8'h02);
    rchk("parity indication", 6'h2c, 8'h80);
    rchk("indication cleared", 6'h2c, 8'h00);
    rchk("summary cleared", 6'h00, 8'h00);
    wr(6'h30, 8'h03);
    txst <= 6'b000010;
    cycles(5);
    chk("pin gated", irq_n, 1'b1);
    rchk("cell sent", 6'h2c, 8'h08);
    rchk("level is no event", 6'h2c, 8'h00);
    wr(6'h28, 8'h00);
    txst <= 6'b001000;
    cycles(5);
    rchk("disabled event", 6'h2c, 8'h00);
    plcp <= 1'b1;
    rxirq <= 1'b1;
    wr(6'h01, 8'h13);
    wr(6'h30, 8'h07);
    cycles(3);
    rchk("framer and rx summary", 6'h00, 8'h11);
    chk("pin from summary", irq_n, 1'b0);
    i_atm_layer_model.frame(5'h05, 8'h3c, 1'b1);
    cycles(12);
    chk("transmit deselect", tsel, 1'b0);
    chk("receive deselect", rsel, 1'b0);
    $display("interrupt test done");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, awv, wv, bready, arv, rready, wide, plcp, rxirq} = '0;
    {awaddr, araddr, wdata, free, txst, hdr} = '0;
    {bad_count, tests_run, cyc, n_tclr, n_rclr} = '0;
    ce = 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_clav();
    t_idle();
    t_sel();
    t_irq();
    close_out();
  end
endmodule
`default_nettype wire
